// ### logic/shc_pkg.sv
// shc_pkg: constants, register layouts and state type of the serial host
// control register block. Shared by the top module and its power control helper.
package shc_pkg;

  // register address space
  localparam int ADDR_W = 12;
  localparam int MOD_HI = 11;
  localparam int MOD_LO = 8;
  localparam logic [3:0] MODULE_SERIAL = 4'h0;
  localparam logic [7:0] OFFS_HOST_MAIN = 8'h00;
  localparam logic [7:0] OFFS_HOST_AUX = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 12'h001;

  // reset values and writable bits
  localparam logic [7:0] MAIN_RESET = 8'h04;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] AUX_WRITE_MASK = 8'h07;

  // serial slave address; value is arbitrary, low bit comes from select
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h44;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // timing
  localparam int SYS_CLK_NS = 100;
  localparam int GLITCH_NS = 200;
  localparam int GLITCH_CYC = (GLITCH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // clock gating restriction, from the power control setting
  localparam logic [1:0] GATE_ALL = 2'h0;
  localparam logic [1:0] GATE_FIVE_ONLY = 2'h1;
  localparam logic [1:0] GATE_VIDEO_ONLY = 2'h2;
  localparam int CLK_SYS = 0;
  localparam int CLK_VIDEO = 1;
  localparam int CLK_FIVE = 2;
  localparam int ANALOG_DOMAINS = 4;

  // pin lanes of the synchroniser
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SEL = 2;
  localparam int PIN_COUNT = 3;

  typedef struct packed {
    logic slave_select_force;
    logic pad_filter_bypass;
    logic address_advance_off;
    logic aux_synth_off;
    logic video_synth_off;
    logic ref_clk_diff;
    logic logic_clock_gate;
    logic sleep;
  } shc_main_s;

  typedef struct packed {
    logic [4:0] unused;
    logic aux_synth_regulator_off;
    logic video_synth_regulator_off;
    logic read_prefetch;
  } shc_aux_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_SUBH,
    ST_SUBL,
    ST_WDATA,
    ST_RDATA,
    ST_RACK
  } shc_state_e;

endpackage : shc_pkg

// ### logic/shc_pin_sync.sv
// shc_pin_sync: two-flop synchroniser per pin with optional glitch filter.
// Assumes pins idle high (open-drain bus with pull-ups).
`timescale 1ns/100ps
`default_nettype none

module shc_pin_sync #(
  parameter int WIDTH = 3,
  parameter int FILT_CYC = 2
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // control
  input wire logic i_bypass,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic meta;
      logic sync;
      logic [3:0] stable_cnt;
      wire differs = sync != o_level[g];
      always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
          meta <= 1'b1;
          sync <= 1'b1;
        end else begin
          meta <= i_pin[g];
          sync <= meta;
        end
      end
      // filter: a change must persist before it is taken
      always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
          o_level[g] <= 1'b1;
          stable_cnt <= 4'h0;
        end else if (i_bypass || (differs && stable_cnt == 4'(FILT_CYC - 1))) begin
          o_level[g] <= sync;
          stable_cnt <= 4'h0;
        end else if (differs) begin
          stable_cnt <= stable_cnt + 4'h1;
        end else begin
          stable_cnt <= 4'h0;
        end
      end
    end
  endgenerate

endmodule : shc_pin_sync
`default_nettype wire

// ### logic/shc_power_ctrl.sv
// shc_power_ctrl: turns host control bits into registered clock hold and
// power-down levels. Assumes the power control inputs are on i_clk_sys.
`timescale 1ns/100ps
`default_nettype none

module shc_power_ctrl #(
  parameter int DOMAINS = 4
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // register contents
  input wire shc_pkg::shc_main_s i_main,
  input wire shc_pkg::shc_aux_s i_aux,
  // power control settings
  input wire logic [1:0] i_gate_restrict,
  input wire logic [DOMAINS-1:0] i_sleep_keep_mask,
  // power outputs
  output logic [2:0] o_clock_hold,
  output logic [DOMAINS-1:0] o_analog_off,
  output logic o_aux_synth_off,
  output logic o_video_synth_off,
  output logic o_aux_synth_regulator_off,
  output logic o_video_synth_regulator_off
);

  wire gate = i_main.logic_clock_gate;
  wire sleep = i_main.sleep;
  // restriction narrows the gate bit only; sleep still stops every clock
  wire hold_sys = sleep || (gate && i_gate_restrict != shc_pkg::GATE_FIVE_ONLY
                            && i_gate_restrict != shc_pkg::GATE_VIDEO_ONLY);
  wire hold_video = sleep || (gate && i_gate_restrict != shc_pkg::GATE_FIVE_ONLY);
  wire hold_five = sleep || (gate && i_gate_restrict != shc_pkg::GATE_VIDEO_ONLY);
  wire [DOMAINS-1:0] analog_off = {DOMAINS{sleep}} & ~i_sleep_keep_mask;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_clock_hold <= 3'h0;
      o_analog_off <= '0;
      o_aux_synth_off <= 1'b0;
      o_video_synth_off <= 1'b0;
      o_aux_synth_regulator_off <= 1'b0;
      o_video_synth_regulator_off <= 1'b0;
    end else begin
      o_clock_hold[shc_pkg::CLK_SYS] <= hold_sys;
      o_clock_hold[shc_pkg::CLK_VIDEO] <= hold_video;
      o_clock_hold[shc_pkg::CLK_FIVE] <= hold_five;
      o_analog_off <= analog_off;
      o_aux_synth_off <= i_main.aux_synth_off;
      o_video_synth_off <= i_main.video_synth_off;
      o_aux_synth_regulator_off <= i_aux.aux_synth_regulator_off;
      o_video_synth_regulator_off <= i_aux.video_synth_regulator_off;
    end
  end

endmodule : shc_power_ctrl
`default_nettype wire

// ### logic/shc_host_regs.sv
// shc_host_regs: two-wire serial slave holding the two host control
// registers; clock pin is sampled by i_clk_sys, well above its rate.
// Summary of operation
// - Bit 7 set forces chip select to one; clear uses the select pin.
// - Bit 6 set bypasses pad glitch filter and slew control.
// - Bit 5 clear advances register address per byte; set holds it.
// - Bit 4 set powers down the auxiliary synthesiser.
// - Bit 3 set powers down the video synthesiser.
// - Bit 2 picks differential reference input; resets to one.
// - Bit 1 set holds system, video and five-times clocks high.
// - Power control setting restricts gating to five-times or video clock.
// - Bit 0 set enters sleep: clocks gated, analog powered down.
// - Sleep leaves powered analog domains excluded by the keep mask.
// - Second register bit 2 powers down the auxiliary synth regulator.
// - Second register bit 1 powers down the video synth regulator.
// - Second register bit 0 enables read prefetch; resets disabled.
// - Prefetch may fetch, and pop, a byte the host never reads.
// - Address bits 11:8 select module; zero selects these serial registers when i_serial_host_sel is set.
`timescale 1ns/100ps
`default_nettype none

module shc_host_regs #(
  parameter logic [6:0] SLAVE_ADDR = shc_pkg::SLAVE_ADDR_DEFAULT,
  parameter int ANALOG_DOMAINS = shc_pkg::ANALOG_DOMAINS,
  parameter int GLITCH_CYC = shc_pkg::GLITCH_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // two-wire serial pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic i_slave_select_pin,
  // chip configuration inputs
  input wire logic i_serial_host_sel,
  input wire logic [1:0] i_gate_restrict,
  input wire logic [ANALOG_DOMAINS-1:0] i_sleep_keep_mask,
  // pad and clock controls
  output logic o_pad_filter_bypass,
  output logic o_ref_clk_diff,
  output logic [2:0] o_clock_hold,
  output logic [ANALOG_DOMAINS-1:0] o_analog_off,
  output logic o_aux_synth_off,
  output logic o_video_synth_off,
  output logic o_aux_synth_regulator_off,
  output logic o_video_synth_regulator_off,
  // read fetch notice for fifo-backed registers elsewhere
  output logic o_read_pulse,
  output logic [shc_pkg::ADDR_W-1:0] o_read_addr
);

  shc_pkg::shc_main_s host_main;
  shc_pkg::shc_aux_s host_aux;
  shc_pkg::shc_state_e state;
  logic [shc_pkg::PIN_COUNT-1:0] pin_lvl;
  logic scl_d;
  logic sda_d;
  logic [3:0] bit_cnt;
  logic in_ack;
  logic rw_read;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [shc_pkg::ADDR_W-1:0] addr;

  shc_pin_sync #(
    .WIDTH(shc_pkg::PIN_COUNT),
    .FILT_CYC(GLITCH_CYC)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_bypass(host_main.pad_filter_bypass),
    .i_pin({i_slave_select_pin, i_sda, i_scl}),
    .o_level(pin_lvl)
  );

  // power levels registered inside, one cycle late
  shc_power_ctrl #(
    .DOMAINS(ANALOG_DOMAINS)
  ) u_power (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_main(host_main),
    .i_aux(host_aux),
    .i_gate_restrict(i_gate_restrict),
    .i_sleep_keep_mask(i_sleep_keep_mask),
    .o_clock_hold(o_clock_hold),
    .o_analog_off(o_analog_off),
    .o_aux_synth_off(o_aux_synth_off),
    .o_video_synth_off(o_video_synth_off),
    .o_aux_synth_regulator_off(o_aux_synth_regulator_off),
    .o_video_synth_regulator_off(o_video_synth_regulator_off)
  );

  wire scl = pin_lvl[shc_pkg::PIN_SCL];
  wire sda = pin_lvl[shc_pkg::PIN_SDA];
  wire sel_pin = pin_lvl[shc_pkg::PIN_SEL];

  // bus events
  wire scl_rise = scl && !scl_d;
  wire scl_fall = !scl && scl_d;
  wire start_det = scl && scl_d && sda_d && !sda;
  wire stop_det = scl && scl_d && !sda_d && sda;

  wire sel_eff = host_main.slave_select_force || sel_pin;
  wire dev_match = shreg[7:1] == {SLAVE_ADDR[6:1], sel_eff};

  // module select on address bits 11:8
  wire mod_hit = i_serial_host_sel && addr[shc_pkg::MOD_HI:shc_pkg::MOD_LO]
                 == shc_pkg::MODULE_SERIAL;
  wire hit_main = mod_hit && addr[7:0] == shc_pkg::OFFS_HOST_MAIN;
  wire hit_aux = mod_hit && addr[7:0] == shc_pkg::OFFS_HOST_AUX;
  wire [7:0] rd_mux = hit_main ? host_main : (hit_aux ? host_aux : 8'h00);

  wire [shc_pkg::ADDR_W-1:0] addr_adv = host_main.address_advance_off ? addr
                                        : addr + shc_pkg::ADDR_STEP;

  wire receiving = state == shc_pkg::ST_DEV || state == shc_pkg::ST_SUBH
                   || state == shc_pkg::ST_SUBL || state == shc_pkg::ST_WDATA;
  wire bit_in = scl_rise && receiving && !in_ack && bit_cnt != shc_pkg::BYTE_BITS;
  wire byte_in = scl_fall && receiving && !in_ack && bit_cnt == shc_pkg::BYTE_BITS;
  wire ack_end = scl_fall && in_ack;
  wire wr_now = byte_in && state == shc_pkg::ST_WDATA;
  wire byte_out_done = scl_fall && state == shc_pkg::ST_RDATA
                       && bit_cnt == shc_pkg::BYTE_BITS;
  wire host_acked = scl_rise && state == shc_pkg::ST_RACK && !sda;

  // prefetch chooses when the next byte is fetched
  wire fetch_first = ack_end && state == shc_pkg::ST_DEV && rw_read;
  // prefetch fetches before the host acks
  wire fetch_pf = byte_out_done && host_aux.read_prefetch;
  wire fetch_ack = host_acked && !host_aux.read_prefetch;
  wire fetch = fetch_first || fetch_pf || fetch_ack;

  // subaddress bytes land in the register address
  wire load_sub_hi = byte_in && state == shc_pkg::ST_SUBH;
  wire load_sub_lo = byte_in && state == shc_pkg::ST_SUBL;
  // one step per written or fetched byte
  wire step_addr = wr_now || fetch;

  // register write strobes and masked aux data
  wire wr_main = wr_now && hit_main;
  wire wr_aux = wr_now && hit_aux;
  wire [7:0] aux_wdata = shreg & shc_pkg::AUX_WRITE_MASK;

  // one-cycle delayed levels for edge detection

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // protocol engine; start and stop take priority over bit traffic
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      state <= shc_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      rw_read <= 1'b0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      o_sda_oe_n <= 1'b1;
    end else if (start_det) begin
      state <= shc_pkg::ST_DEV;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      state <= shc_pkg::ST_IDLE;
      in_ack <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else if (bit_in) begin
      shreg <= {shreg[6:0], sda};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (byte_in) begin
      // address miss: step off the bus until the next start
      if (state == shc_pkg::ST_DEV && !dev_match) begin
        state <= shc_pkg::ST_IDLE;
      end else begin
        in_ack <= 1'b1;
        o_sda_oe_n <= 1'b0;
      end
      if (state == shc_pkg::ST_DEV) begin
        rw_read <= shreg[0];
      end
    end else if (ack_end) begin
      in_ack <= 1'b0;
      bit_cnt <= 4'h0;
      o_sda_oe_n <= 1'b1;
      case (state)
        shc_pkg::ST_DEV: begin
          if (rw_read) begin
            // first data bit goes out on the same falling edge
            state <= shc_pkg::ST_RDATA;
            o_sda_oe_n <= rd_mux[7];
            txreg <= {rd_mux[6:0], 1'b0};
            bit_cnt <= 4'h1;
          end else begin
            state <= shc_pkg::ST_SUBH;
          end
        end
        shc_pkg::ST_SUBH: begin
          state <= shc_pkg::ST_SUBL;
        end
        default: begin
          state <= shc_pkg::ST_WDATA;
        end
      endcase
    end else if (scl_fall && state == shc_pkg::ST_RDATA) begin
      if (bit_cnt == shc_pkg::BYTE_BITS) begin
        o_sda_oe_n <= 1'b1;
        state <= shc_pkg::ST_RACK;
        bit_cnt <= 4'h0;
        if (fetch_pf) begin
          txreg <= rd_mux;
        end
      end else begin
        o_sda_oe_n <= txreg[7];
        txreg <= {txreg[6:0], 1'b0};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end else if (scl_rise && state == shc_pkg::ST_RACK) begin
      // host not-acknowledge ends the read burst
      state <= sda ? shc_pkg::ST_IDLE : shc_pkg::ST_RDATA;
      if (fetch_ack) begin
        txreg <= rd_mux;
      end
    end
  end

  // register address: subaddress bytes, then advance per byte moved
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      addr <= '0;
    end else if (load_sub_hi) begin
      addr[shc_pkg::MOD_HI:shc_pkg::MOD_LO] <= shreg[3:0];
    end else if (load_sub_lo) begin
      addr[7:0] <= shreg;
    end else if (step_addr) begin
      addr <= addr_adv;
    end
  end

  // host control registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      host_main <= shc_pkg::MAIN_RESET;
      host_aux <= shc_pkg::AUX_RESET;
    end else if (wr_main) begin
      host_main <= shreg;
    end else if (wr_aux) begin
      host_aux <= aux_wdata;
    end
  end

  // fetch notice lets fifo sources pop on prefetch too
  // a nacked prefetch still pulses, so that byte is lost to the host
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_read_pulse <= 1'b0;
      o_read_addr <= '0;
    end else begin
      o_read_pulse <= fetch;
      if (fetch) begin
        o_read_addr <= addr;
      end
    end
  end

  // pad controls; data value stays low, the enable alone moves the pin
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_sda <= 1'b0;
      o_pad_filter_bypass <= 1'b0;
      o_ref_clk_diff <= 1'b1;
    end else begin
      o_sda <= 1'b0;
      o_pad_filter_bypass <= host_main.pad_filter_bypass;
      o_ref_clk_diff <= host_main.ref_clk_diff;
    end
  end

endmodule : shc_host_regs
`default_nettype wire

// ### test/shc_host_regs_assertions.sv
// shc_host_regs_assertions: port checks on the host control block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module shc_host_regs_assertions #(
  parameter int ANALOG_DOMAINS = 4
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // configuration inputs
  input wire logic [1:0] i_gate_restrict,
  input wire logic [ANALOG_DOMAINS-1:0] i_sleep_keep_mask,
  // watched outputs
  input wire logic [2:0] o_clock_hold,
  input wire logic [ANALOG_DOMAINS-1:0] o_analog_off,
  input wire logic o_ref_clk_diff,
  input wire logic o_aux_synth_off,
  input wire logic o_video_synth_off,
  input wire logic o_aux_synth_regulator_off,
  input wire logic o_video_synth_regulator_off,
  input wire logic o_read_pulse
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  chk_keep_mask: assert property ((o_analog_off & $past(i_sleep_keep_mask)) == '0)
    else $error("kept analog domain powered down");
  chk_sleep_gates: assert property (o_analog_off != '0 |-> o_clock_hold == 3'h7)
    else $error("sleep without all clocks held");
  chk_gate_set: assert property (o_clock_hold inside {3'h0, 3'h2, 3'h4, 3'h7})
    else $error("partial clock hold pattern");
  chk_gate_five: assert property ($past(i_gate_restrict) == 2'h1 && o_analog_off == '0
    |-> o_clock_hold inside {3'h0, 3'h4})
    else $error("five-times restriction ignored");
  chk_gate_video: assert property ($past(i_gate_restrict) == 2'h2 && o_analog_off == '0
    |-> o_clock_hold inside {3'h0, 3'h2})
    else $error("video restriction ignored");
  chk_ref_reset: assert property ($rose(i_reset_n) |-> o_ref_clk_diff)
    else $error("reference select not one after reset");
  chk_synth_reset: assert property ($rose(i_reset_n) |-> !o_aux_synth_off && !o_video_synth_off)
    else $error("synthesiser off after reset");
  chk_regul_reset: assert property ($rose(i_reset_n)
    |-> !o_aux_synth_regulator_off && !o_video_synth_regulator_off)
    else $error("regulator off after reset");
  chk_pulse_gap: assert property (o_read_pulse |=> !o_read_pulse [*8])
    else $error("read fetches too close");
  cover property (o_read_pulse);
  cover property (o_analog_off != '0);
  cover property (o_clock_hold == 3'h4);
endmodule : shc_host_regs_assertions
bind shc_host_regs shc_host_regs_assertions #(.ANALOG_DOMAINS(ANALOG_DOMAINS)) u_chk (
  .i_clk_sys, .i_reset_n, .i_gate_restrict, .i_sleep_keep_mask, .o_clock_hold,
  .o_analog_off, .o_ref_clk_diff, .o_aux_synth_off, .o_video_synth_off,
  .o_aux_synth_regulator_off, .o_video_synth_regulator_off, .o_read_pulse);
`default_nettype wire

// ### test/shc_i2c_host.sv
// shc_i2c_host: behavioural two-wire bus host, 800 ns clock period.
// Assumes a pull-up on the data line, so releasing means driving one.
`timescale 1ns/100ps
`default_nettype none
module shc_i2c_host (
  // clock
  input wire logic i_clk_sys,
  // bus pins
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda,
  // finished byte
  output logic o_done,
  output logic [8:0] o_rx
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_done = 1'b0;
    o_rx = '0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : w
  // long low phase first: the slave may still hold its ack
  task automatic start();
    w(4);
    o_sda = 1'b1;
    w(2);
    o_scl = 1'b1;
    w(4);
    o_sda = 1'b0;
    w(4);
    o_scl = 1'b0;
  endtask : start
  task automatic bits(input logic [8:0] tx);
    for (int i = 8; i >= 0; i--) begin
      w(2);
      o_sda = tx[i];
      w(3);
      o_scl = 1'b1;
      w(3);
      o_rx[i] = i_sda;
      o_scl = 1'b0;
    end
    o_done = 1'b1;
    w(1);
    o_done = 1'b0;
  endtask : bits
  task automatic stop();
    w(4);
    o_sda = 1'b0;
    w(2);
    o_scl = 1'b1;
    w(4);
    o_sda = 1'b1;
    w(8);
  endtask : stop
endmodule : shc_i2c_host
`default_nettype wire

// ### test/shc_host_regs_tb_top.sv
// shc_host_regs_tb_top: self-checking bench for the host control block.
// Assumes the bus host model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module shc_host_regs_tb_top;
  localparam logic [6:0] SA = shc_pkg::SLAVE_ADDR_DEFAULT;
  localparam logic [11:0] HOLD_TAB [4] = '{12'h7, 12'h4, 12'h2, 12'h7};
  typedef struct { string nm; logic [8:0] e; } shc_exp_s;
  shc_exp_s exp_q[$];
  shc_exp_s cur;
  logic clk, rst_n, scl, sda_h, sda_line, o_sda, oe_n, sel_pin, host_sel, cs, done;
  logic [1:0] gate_sel;
  logic [3:0] keep, aoff;
  logic [2:0] hold;
  logic [7:0] d;
  logic [8:0] rx;
  logic [11:0] raddr, pulses;
  logic bypass, refd, aux_off, vid_off, aux_reg, vid_reg, rpulse;
  int num_errors = 0;
  int check_count = 0;
  assign sda_line = sda_h & (oe_n | o_sda);
  shc_host_regs u_dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda_line), .o_sda(o_sda),
    .o_sda_oe_n(oe_n), .i_slave_select_pin(sel_pin), .i_serial_host_sel(host_sel),
    .i_gate_restrict(gate_sel), .i_sleep_keep_mask(keep), .o_pad_filter_bypass(bypass),
    .o_ref_clk_diff(refd), .o_clock_hold(hold), .o_analog_off(aoff),
    .o_aux_synth_off(aux_off), .o_video_synth_off(vid_off),
    .o_aux_synth_regulator_off(aux_reg), .o_video_synth_regulator_off(vid_reg),
    .o_read_pulse(rpulse), .o_read_addr(raddr));
  shc_i2c_host u_host (
    .i_clk_sys(clk), .i_sda(sda_line), .o_scl(scl), .o_sda(sda_h), .o_done(done), .o_rx(rx));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (rpulse === 1'b1) pulses <= pulses + 12'h001;
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bus results come back in order, oldest note first
  always @(posedge done) begin
    cur = exp_q.pop_front();
    chk(cur.nm, {3'h0, cur.e}, {3'h0, rx});
  end
  task automatic xb(input string nm, input logic [8:0] tx, input logic [8:0] ex);
    exp_q.push_back('{nm, ex});
    u_host.bits(tx);
  endtask : xb
  task automatic put(input logic [7:0] v);
    xb("write ack", {v, 1'b1}, {v, 1'b0});
  endtask : put
  task automatic get(input logic [7:0] e, input logic last);
    xb("read byte", {8'hFF, last}, {e, last});
  endtask : get
  task automatic hdr(input logic [11:0] a);
    u_host.start();
    put({SA[6:1], cs, 1'b0});
    put({4'h0, a[11:8]});
    put(a[7:0]);
  endtask : hdr
  task automatic rdr();
    u_host.start();
    put({SA[6:1], cs, 1'b1});
  endtask : rdr
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    hdr(a);
    put(v);
    u_host.stop();
  endtask : wr
  task automatic rd1(input logic [11:0] a, input logic [7:0] e);
    hdr(a);
    rdr();
    get(e, 1'b1);
    u_host.stop();
  endtask : rd1
  task automatic nack(input logic c);
    u_host.start();
    xb("select nack", {SA[6:1], c, 2'b01}, {SA[6:1], c, 2'b01});
    u_host.stop();
  endtask : nack
  task automatic reset_dut();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : reset_dut
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    {sel_pin, host_sel, cs, gate_sel, keep, pulses} = {3'b111, 2'h0, 4'h0, 12'h000};
    void'($urandom(32'hFEED));
    reset_dut();
    chk("ref diff", 12'h1, {11'h0, refd});
    rd1(12'h000, shc_pkg::MAIN_RESET);
    rd1(12'h001, shc_pkg::AUX_RESET);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom()) & 8'h1E;
      wr(12'h000, d);
      chk("synth off", {10'h0, d[4:3]}, {10'h0, aux_off, vid_off});
      chk("ref diff", {11'h0, d[2]}, {11'h0, refd});
      chk("clock hold", d[1] ? 12'h7 : 12'h0, {9'h0, hold});
      rd1(12'h000, d);
    end
    wr(12'h000, 8'h02);
    for (int r = 0; r < 4; r++) begin
      gate_sel = 2'(r);
      repeat (2) @(negedge clk);
      chk("restricted hold", HOLD_TAB[r], {9'h0, hold});
    end
    $display("test gating done");
    gate_sel = 2'h1;
    keep = 4'($urandom()) & 4'h7;
    wr(12'h000, 8'h01);
    chk("analog off", {8'h0, ~keep}, {8'h0, aoff});
    chk("sleep hold", 12'h7, {9'h0, hold});
    wr(12'h000, 8'h04);
    chk("awake", 12'h0, {8'h0, aoff});
    $display("test sleep done");
    wr(12'h001, 8'hFF);
    chk("regulators", 12'h3, {10'h0, aux_reg, vid_reg});
    pulses = 12'h000;
    rd1(12'h001, 8'h07);
    chk("prefetch fetches", 12'h2, pulses);
    chk("fetch addr", 12'h002, raddr);
    wr(12'h001, 8'h00);
    pulses = 12'h000;
    rd1(12'h001, 8'h00);
    chk("plain fetches", 12'h1, pulses);
    $display("test prefetch done");
    hdr(12'h000);
    put(8'h04);
    put(8'h02);
    u_host.stop();
    hdr(12'h000);
    rdr();
    get(8'h04, 1'b0);
    get(8'h02, 1'b1);
    u_host.stop();
    wr(12'h000, 8'h24);
    hdr(12'h000);
    put(8'h34);
    put(8'h30);
    u_host.stop();
    chk("aux kept", 12'h1, {10'h0, aux_reg, vid_reg});
    rd1(12'h000, 8'h30);
    wr(12'h000, 8'h04);
    $display("test advance done");
    sel_pin = 1'b0;
    nack(1'b1);
    cs = 1'b0;
    wr(12'h000, 8'h84);
    nack(1'b0);
    cs = 1'b1;
    rd1(12'h000, 8'h84);
    wr(12'h000, 8'h04);
    sel_pin = 1'b1;
    $display("test select done");
    wr(12'h100, 8'h5A);
    rd1(12'h100, 8'h00);
    host_sel = 1'b0;
    wr(12'h000, 8'h10);
    rd1(12'h000, 8'h00);
    chk("decode off", 12'h0, {11'h0, aux_off});
    host_sel = 1'b1;
    wr(12'h000, 8'h40);
    chk("pad bypass", 12'h1, {11'h0, bypass});
    rd1(12'h000, 8'h40);
    reset_dut();
    chk("bypass reset", 12'h0, {11'h0, bypass});
    rd1(12'h000, shc_pkg::MAIN_RESET);
    $display("test decode done");
    report_and_stop();
  end
endmodule : shc_host_regs_tb_top
`default_nettype wire
